// ==== hdl/csh_consts.vh ====
// Constants for the component sorter handler port.
// Assumes a 40 MHz core clock; included by bare name.
`ifndef CSH_CONSTS_VH
`define CSH_CONSTS_VH

`define CSH_CLK_MHZ 40
`define CSH_BIN_COUNT 9
`define CSH_BIN_IDX_W 4
`define CSH_BIN_NONE 4'h0
`define CSH_BIN_OUT_DELAY_US 200
`define CSH_BIN_OUT_DELAY_CYC (`CSH_BIN_OUT_DELAY_US * `CSH_CLK_MHZ)
`define CSH_MATH_TIME_US 1000
`define CSH_MATH_TIME_CYC (`CSH_MATH_TIME_US * `CSH_CLK_MHZ)
`define CSH_CNT_W 20
`define CSH_ALL_OFF 9'h1ff

`endif

// ==== hdl/csh_timer.v ====
// Down-counting delay timer used for the math and bin-delay phases of a measurement cycle.
// Assumes load and the count come from the sequencer in the same clock.
`timescale 1ns/100ps
`default_nettype none

module csh_timer #(
    parameter CNT_W = 20
) (
    input wire core_clk,
    input wire sys_rst,
    input wire load,
    input wire [CNT_W-1:0] load_val,
    output reg expired
);

    reg [CNT_W-1:0] count_reg;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg <= {CNT_W{1'b0}};
            expired <= 1'b0;
        end else if (load) begin
            count_reg <= load_val;
            expired <= 1'b0;
        end else if (count_reg > {{(CNT_W-1){1'b0}}, 1'b1}) begin
            count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
            expired <= 1'b0;
        end else begin
            count_reg <= {CNT_W{1'b0}};
            expired <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// ==== hdl/csh_handler_port.v ====
// Handler port sequencer: trigger in, sorting and status lines out.
// Assumes the comparator core supplies results when conv_done pulses,
// and all inputs are synchronous to core_clk.
//
// Summary of operation
// - One low bin line per sorting bin
// - Secondary over low on fail, when aux on
// - Primary over is high OR low fail
// - Primary high fail above upper limit
// - Primary low fail below lower limit
// - Overall fail is secondary OR primary over
// - Index low during conversion
// - Done low while test in progress
// - Rising trigger edge starts a measurement when idle; edges during a test are ignored
// - Keypad locked while lock input low
// - Bin outputs settle 200 us before done
`timescale 1ns/100ps
`default_nettype none
`include "csh_consts.vh"

module csh_handler_port #(
    parameter BIN_COUNT = `CSH_BIN_COUNT,
    parameter BIN_DELAY_CYC = `CSH_BIN_OUT_DELAY_CYC,
    parameter MATH_CYC = `CSH_MATH_TIME_CYC
) (
    input wire core_clk,
    input wire sys_rst,
    input wire ext_trigger_in,
    input wire keypad_lock_n_in,
    input wire aux_enable,
    input wire conv_done,
    input wire [`CSH_BIN_IDX_W-1:0] result_bin,
    input wire result_pri_high,
    input wire result_pri_low,
    input wire result_sec_fail,
    output reg meas_start,
    output reg keypad_enable,
    output reg [BIN_COUNT-1:0] bin_result_n,
    output reg sec_over_fail_n,
    output reg primary_over_fail_n,
    output reg primary_high_fail_n,
    output reg primary_low_fail_n,
    output reg overall_fail_n,
    output reg conv_busy_n,
    output reg measure_done
);

    // -------------------------------------------------------------
    // States
    // -------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_CONV = 4'h2;
    localparam [3:0] ST_MATH = 4'h4;
    localparam [3:0] ST_BIN = 4'h8;

    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg trig_last_reg;
    reg timer_load;
    reg [`CSH_CNT_W-1:0] timer_val;
    reg [`CSH_BIN_IDX_W-1:0] bin_hold_reg;
    reg pri_high_reg;
    reg pri_low_reg;
    reg sec_fail_reg;
    wire timer_expired;
    wire trig_rise;

    // Decode a bin index into one-hot active-low lines
    function [BIN_COUNT-1:0] bin_decode_n;
        input [`CSH_BIN_IDX_W-1:0] idx;
        integer i;
        begin
            bin_decode_n = {BIN_COUNT{1'b1}};
            for (i = 0; i < BIN_COUNT; i = i + 1) begin
                if (idx == i + 1) begin
                    bin_decode_n[i] = 1'b0;
                end
            end
        end
    endfunction

    csh_timer #(
        .CNT_W(`CSH_CNT_W)
    ) u_timer (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(timer_load),
        .load_val(timer_val),
        .expired(timer_expired)
    );

    // -------------------------------------------------------------
    // Trigger edge detect
    // -------------------------------------------------------------
    // Rising edge detect
    assign trig_rise = ext_trigger_in & ~trig_last_reg;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trig_last_reg <= 1'b1;
        end else begin
            trig_last_reg <= ext_trigger_in;
        end
    end

    // -------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        timer_load = 1'b0;
        timer_val = {`CSH_CNT_W{1'b0}};
        case (state_reg)
            ST_IDLE: begin
                if (trig_rise) begin
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_done) begin
                    state_next = ST_MATH;
                    timer_load = 1'b1;
                    timer_val = MATH_CYC[`CSH_CNT_W-1:0];
                end
            end
            ST_MATH: begin
                if (timer_expired) begin
                    state_next = ST_BIN;
                    timer_load = 1'b1;
                    timer_val = BIN_DELAY_CYC[`CSH_CNT_W-1:0];
                end
            end
            ST_BIN: begin
                if (timer_expired) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            meas_start <= 1'b0;
            conv_busy_n <= 1'b1;
            measure_done <= 1'b1;
        end else begin
            state_reg <= state_next;
            meas_start <= (state_reg == ST_IDLE) && trig_rise;
            conv_busy_n <= ~(state_next == ST_CONV);
            measure_done <= (state_next == ST_IDLE);
        end
    end

    // -------------------------------------------------------------
    // Result capture
    // -------------------------------------------------------------
    // Results latch on conv_done and drive the lines at the end of math, so lines change once per cycle
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bin_hold_reg <= `CSH_BIN_NONE;
            pri_high_reg <= 1'b0;
            pri_low_reg <= 1'b0;
            sec_fail_reg <= 1'b0;
        end else if (state_reg == ST_CONV && conv_done) begin
            bin_hold_reg <= result_bin;
            pri_high_reg <= result_pri_high;
            pri_low_reg <= result_pri_low;
            sec_fail_reg <= result_sec_fail & aux_enable;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bin_result_n <= `CSH_ALL_OFF;
            sec_over_fail_n <= 1'b1;
            primary_over_fail_n <= 1'b1;
            primary_high_fail_n <= 1'b1;
            primary_low_fail_n <= 1'b1;
            overall_fail_n <= 1'b1;
        end else if (state_reg == ST_MATH && timer_expired) begin
            bin_result_n <= bin_decode_n(bin_hold_reg);
            sec_over_fail_n <= ~sec_fail_reg;
            primary_over_fail_n <= ~(pri_high_reg | pri_low_reg);
            primary_high_fail_n <= ~pri_high_reg;
            primary_low_fail_n <= ~pri_low_reg;
            overall_fail_n <= ~(sec_fail_reg | pri_high_reg | pri_low_reg);
        end
    end

    // -------------------------------------------------------------
    // Keypad lock
    // -------------------------------------------------------------
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            keypad_enable <= 1'b1;
        end else begin
            keypad_enable <= keypad_lock_n_in;
        end
    end

endmodule

`default_nettype wire

// ==== tb/csh_port_monitor.sv ====
// Handler port checker, bound to csh_handler_port.
// Assumes one clock domain.
`timescale 1ns/100ps
`default_nettype none
// ---
// Checker
// ---
module csh_port_chk #(
    parameter BIN_COUNT = 9,
    parameter BIN_DELAY_CYC = 3
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ext_trigger_in,
    input wire logic conv_done,
    input wire logic meas_start,
    input wire logic [BIN_COUNT-1:0] bin_result_n,
    input wire logic sec_over_fail_n,
    input wire logic primary_over_fail_n,
    input wire logic primary_high_fail_n,
    input wire logic primary_low_fail_n,
    input wire logic overall_fail_n,
    input wire logic conv_busy_n,
    input wire logic measure_done
);
    wire [BIN_COUNT+2:0] res = {bin_result_n, sec_over_fail_n, primary_high_fail_n, primary_low_fail_n};
    // Wide enough for the full-size bin delay count, not only the shortened bench value
    logic [31:0] calm_reg;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Saturating age of the result lines
    always @(posedge core_clk or posedge sys_rst)
        if (sys_rst) calm_reg <= 32'h00000000;
        else if ($changed(res)) calm_reg <= 32'h00000000;
        else if (calm_reg != 32'hffffffff) calm_reg <= calm_reg + 32'h00000001;
    one_bin_a: assert property ($countones(~bin_result_n) <= 1) else $error("bins");
    pri_or_a: assert property (primary_over_fail_n == (primary_high_fail_n & primary_low_fail_n)) else $error("p");
    fail_or_a: assert property (overall_fail_n == (sec_over_fail_n & primary_over_fail_n)) else $error("ng");
    trig_start_a: assert property (!$past(sys_rst) && $rose(ext_trigger_in) && measure_done
        |=> meas_start && !measure_done && !conv_busy_n) else $error("start");
    busy_ignore_a: assert property (!measure_done |=> !meas_start) else $error("restart");
    conv_end_a: assert property (conv_done && !conv_busy_n |=> conv_busy_n) else $error("busy");
    bin_delay_a: assert property ($rose(measure_done) |-> calm_reg >= BIN_DELAY_CYC - 1) else $error("dly");
    res_hold_a: assert property ($changed(res) |-> !measure_done) else $error("hold");
    cover property (meas_start);
    cover property ($rose(measure_done));
    cover property (!overall_fail_n && !sec_over_fail_n);
endmodule
bind csh_handler_port csh_port_chk #(.BIN_COUNT(BIN_COUNT), .BIN_DELAY_CYC(BIN_DELAY_CYC)) u_chk (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ext_trigger_in(ext_trigger_in),
    .conv_done(conv_done),
    .meas_start(meas_start),
    .bin_result_n(bin_result_n),
    .sec_over_fail_n(sec_over_fail_n),
    .primary_over_fail_n(primary_over_fail_n),
    .primary_high_fail_n(primary_high_fail_n),
    .primary_low_fail_n(primary_low_fail_n),
    .overall_fail_n(overall_fail_n),
    .conv_busy_n(conv_busy_n),
    .measure_done(measure_done)
);
`default_nettype wire

// ==== tb/csh_core_model.sv ====
// Comparator core stand-in: answers meas_start with a conv_done pulse.
// Assumes want and lat are held through the test.
`timescale 1ns/100ps
`default_nettype none
module csh_core_model (
    input wire logic core_clk,
    input wire logic meas_start,
    input wire logic [7:0] lat,
    input wire logic [6:0] want,
    output var logic conv_done = 1'b0,
    output var logic [6:0] res = 7'h00
);
    logic [7:0] cnt_reg = 8'h00;
    // Off-pulse lines carry the inverse so a late sample shows up
    always @(posedge core_clk) begin
        conv_done <= 1'b0;
        res <= ~want;
        if (meas_start) cnt_reg <= lat;
        else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
        if (!meas_start && cnt_reg == 8'h01) begin
            conv_done <= 1'b1;
            res <= want;
        end
    end
endmodule
`default_nettype wire

// ==== tb/csh_handler_port_tb.sv ====
// Bench for csh_handler_port with a core stand-in.
// Assumes shortened timer parameters.
`timescale 1ns/100ps
`default_nettype none
module csh_handler_port_tb;
    logic core_clk = 1'b0, sys_rst = 1'b1, ext_trigger_in = 1'b0, keypad_lock_n_in = 1'b1, aux_enable = 1'b0;
    logic conv_done, meas_start, keypad_enable;
    logic [6:0] core_res;
    logic sec_over_fail_n, primary_over_fail_n, primary_high_fail_n, primary_low_fail_n, overall_fail_n;
    logic conv_busy_n, measure_done;
    logic [8:0] bin_result_n;
    logic [7:0] lat = 8'h01;
    logic [6:0] want = 7'h00;
    integer err_total = 0, comparisons = 0, starts = 0, exp_starts = 0, seed = 32'h823e97e0, i;
    wire [13:0] outs = {bin_result_n, sec_over_fail_n, primary_over_fail_n, primary_high_fail_n,
        primary_low_fail_n, overall_fail_n};
    csh_handler_port #(.MATH_CYC(4), .BIN_DELAY_CYC(3)) DUT (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .ext_trigger_in(ext_trigger_in),
        .keypad_lock_n_in(keypad_lock_n_in),
        .aux_enable(aux_enable),
        .conv_done(conv_done),
        .result_bin(core_res[6:3]),
        .result_pri_high(core_res[2]),
        .result_pri_low(core_res[1]),
        .result_sec_fail(core_res[0]),
        .meas_start(meas_start),
        .keypad_enable(keypad_enable),
        .bin_result_n(bin_result_n),
        .sec_over_fail_n(sec_over_fail_n),
        .primary_over_fail_n(primary_over_fail_n),
        .primary_high_fail_n(primary_high_fail_n),
        .primary_low_fail_n(primary_low_fail_n),
        .overall_fail_n(overall_fail_n),
        .conv_busy_n(conv_busy_n),
        .measure_done(measure_done)
    );
    csh_core_model u_core (
        .core_clk(core_clk),
        .meas_start(meas_start),
        .lat(lat),
        .want(want),
        .conv_done(conv_done),
        .res(core_res)
    );
    initial forever #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (meas_start) starts <= starts + 1;
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    function automatic logic [13:0] exp_out(input logic [6:0] w, input logic a);
        logic f;
        f = w[0] & a;
        exp_out = {9'h1ff, ~f, ~(w[2] | w[1]), ~w[2], ~w[1], ~(f | w[2] | w[1])};
        if (w[6:3] >= 4'h1 && w[6:3] <= 4'h9) exp_out[13:5] = ~(9'h001 << (w[6:3] - 4'h1));
    endfunction
    task report_and_stop;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        report_and_stop;
    end
    initial begin
        repeat (5) @(posedge core_clk);
        @(negedge core_clk) chk({outs, measure_done, conv_busy_n, meas_start, keypad_enable}, 18'h3fffd);
        @(posedge core_clk) sys_rst <= 1'b0;
        // Bins 0..15 first, then random results
        for (i = 0; i < 48; i++) begin
            @(posedge core_clk) ext_trigger_in <= 1'b1;
            want <= (i < 16) ? {4'(i), 3'(i)} : 7'($random(seed));
            aux_enable <= 1'($random(seed));
            keypad_lock_n_in <= 1'($random(seed));
            lat <= 8'h01 + 8'($unsigned($random(seed)) % 6);
            exp_starts++;
            @(posedge core_clk);
            @(negedge core_clk) chk({meas_start, measure_done, conv_busy_n}, 18'h4);
            @(posedge core_clk) ext_trigger_in <= 1'b0;
            @(posedge core_clk) ext_trigger_in <= 1'b1;
            @(posedge core_clk) ext_trigger_in <= 1'b0;
            repeat (80) if (!measure_done) @(negedge core_clk);
            chk({outs, conv_busy_n, measure_done}, {exp_out(want, aux_enable), 2'b11});
            chk(18'(starts), 18'(exp_starts));
            chk(keypad_enable, keypad_lock_n_in);
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
